// ---- rtl/sis_inserter.sv ----
// Image signature inserter: register file, counters and byte stream insertion
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module sis_inserter
  import sis_pkg::*;
#(
  parameter int DATA_W = 32
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [31:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic [15:0] image_height,
  input wire logic integration_start,
  input wire logic frame_readout,
  input wire logic ext_trigger,
  input wire logic seq_active,
  input wire logic [31:0] seq_user_tag_value,
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  input wire logic in_sof,
  input wire logic in_eol,
  input wire logic in_eof,
  input wire logic in_pad,
  output logic out_valid,
  output logic [7:0] out_data,
  output logic out_sof,
  output logic out_eol,
  output logic out_eof,
  output logic out_pad
);
  // ************************************************************
  // Cycle timer
  // ************************************************************
  logic [31:0] cycle_time;

  sis_cycle_timer u_timer (
    .clk(clk),
    .reset(reset),
    .cycle_time(cycle_time)
  );

  // ************************************************************
  // Registers and counters
  // ************************************************************
  logic on_reg, on_next;
  logic [15:0] insert_line_reg, insert_line_next;
  logic [31:0] user_tag_value_reg, user_tag_value_next;
  logic [31:0] frame_cnt_reg, frame_cnt_next;
  logic [31:0] trig_cnt_reg, trig_cnt_next;
  logic [31:0] ct_latch_reg, ct_latch_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;

  always_comb begin
    on_next = on_reg;
    insert_line_next = insert_line_reg;
    user_tag_value_next = user_tag_value_reg;
    if (reg_wr && reg_addr == SIS_CTRL_ADDR) begin
      // Presence bit is not stored, so a write cannot change it
      on_next = reg_wdata[SIS_ON_BIT];
      insert_line_next = reg_wdata[SIS_LINE_LSB +: SIS_LINE_W];
    end
    if (reg_wr && reg_addr == SIS_USER_ADDR) begin
      user_tag_value_next = reg_wdata[31:0];
    end
    frame_cnt_next = frame_readout ? frame_cnt_reg + 32'h00000001 : frame_cnt_reg;
    trig_cnt_next = ext_trigger ? trig_cnt_reg + 32'h00000001 : trig_cnt_reg;
    ct_latch_next = integration_start ? cycle_time : ct_latch_reg;
    rdata_next = '0;
    if (reg_rd) begin
      case (reg_addr)
        SIS_CTRL_ADDR: begin
          rdata_next[SIS_PRESENT_BIT] = 1'b1;
          rdata_next[SIS_ON_BIT] = on_reg;
          rdata_next[SIS_LINE_LSB +: SIS_LINE_W] = insert_line_reg;
        end
        SIS_USER_ADDR: rdata_next[31:0] = user_tag_value_reg;
        SIS_FRMCNT_ADDR: rdata_next[31:0] = frame_cnt_reg;
        SIS_TRGCNT_ADDR: rdata_next[31:0] = trig_cnt_reg;
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      on_reg <= SIS_ON_RESET;
      insert_line_reg <= SIS_LINE_RESET;
      user_tag_value_reg <= SIS_USER_RESET;
      frame_cnt_reg <= 32'h00000000;
      trig_cnt_reg <= 32'h00000000;
      ct_latch_reg <= 32'h00000000;
      rdata_reg <= '0;
    end else begin
      on_reg <= on_next;
      insert_line_reg <= insert_line_next;
      user_tag_value_reg <= user_tag_value_next;
      frame_cnt_reg <= frame_cnt_next;
      trig_cnt_reg <= trig_cnt_next;
      ct_latch_reg <= ct_latch_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // ************************************************************
  // Per-frame snapshot, taken on the first byte of a frame
  // ************************************************************
  logic frame_start;
  logic en_reg, en_next;
  logic hit_ok_reg, hit_ok_next;
  logic [15:0] target_reg, target_next;
  logic [31:0] snap_ct_reg, snap_ct_next;
  logic [31:0] snap_frm_reg, snap_frm_next;
  logic [31:0] snap_trg_reg, snap_trg_next;
  logic [31:0] snap_usr_reg, snap_usr_next;
  logic signed [17:0] from_bottom;

  assign frame_start = in_valid && in_sof;

  // Settings are frozen per frame so a mid-frame write cannot split a signature
  always_comb begin
    en_next = en_reg;
    hit_ok_next = hit_ok_reg;
    target_next = target_reg;
    snap_ct_next = snap_ct_reg;
    snap_frm_next = snap_frm_reg;
    snap_trg_next = snap_trg_reg;
    snap_usr_next = snap_usr_reg;
    from_bottom = $signed({2'b00, image_height}) + $signed({{2{insert_line_reg[15]}}, insert_line_reg});
    if (frame_start) begin
      en_next = on_reg;
      if (!insert_line_reg[15]) begin
        target_next = insert_line_reg;
        hit_ok_next = insert_line_reg <= image_height;
      end else begin
        target_next = from_bottom[15:0];
        hit_ok_next = !from_bottom[17];
      end
      snap_ct_next = ct_latch_reg;
      snap_frm_next = frame_cnt_reg;
      snap_trg_next = trig_cnt_reg;
      snap_usr_next = seq_active ? seq_user_tag_value : user_tag_value_reg;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      en_reg <= 1'b0;
      hit_ok_reg <= 1'b0;
      target_reg <= 16'h0000;
      snap_ct_reg <= 32'h00000000;
      snap_frm_reg <= 32'h00000000;
      snap_trg_reg <= 32'h00000000;
      snap_usr_reg <= 32'h00000000;
    end else begin
      en_reg <= en_next;
      hit_ok_reg <= hit_ok_next;
      target_reg <= target_next;
      snap_ct_reg <= snap_ct_next;
      snap_frm_reg <= snap_frm_next;
      snap_trg_reg <= snap_trg_next;
      snap_usr_reg <= snap_usr_next;
    end
  end

  // ************************************************************
  // Line and byte position
  // ************************************************************
  logic [15:0] line_reg, line_next;
  logic [4:0] byte_reg, byte_next;
  logic [15:0] cur_line;
  logic [4:0] cur_byte;

  always_comb begin
    cur_line = in_sof ? 16'h0000 : line_reg;
    cur_byte = in_sof ? 5'h00 : byte_reg;
    line_next = line_reg;
    byte_next = byte_reg;
    if (in_valid) begin
      byte_next = (cur_byte == SIS_LEN) ? cur_byte : cur_byte + 5'h01;
      line_next = cur_line;
      if (in_eol) begin
        byte_next = 5'h00;
        line_next = cur_line + 16'h0001;
      end
      if (in_eof) begin
        line_next = 16'h0000;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      line_reg <= 16'h0000;
      byte_reg <= 5'h00;
    end else begin
      line_reg <= line_next;
      byte_reg <= byte_next;
    end
  end

  // ************************************************************
  // Byte replacement
  // ************************************************************
  logic ins_now;
  logic [7:0] sig_byte;
  logic [4:0] rel;
  logic [31:0] sig_word;
  logic ins_reg, ins_next;
  logic out_valid_reg, out_sof_reg, out_eol_reg, out_eof_reg, out_pad_reg;
  logic [7:0] out_data_reg, out_data_next;

  // Image lines and padding lines are both counted; target equal to height is the first
  // padding line, and the region check allows a padding line only when the target equals height
  always_comb begin
    ins_now = in_valid && en_next && hit_ok_next && cur_line == target_next
      && (in_pad == (target_next == image_height)) && cur_byte < SIS_LEN;
    sig_word = snap_usr_next;
    rel = cur_byte - SIS_USR_BYTE;
    if (cur_byte < SIS_FRM_BYTE) begin
      sig_word = snap_ct_next;
      rel = cur_byte - SIS_CT_BYTE;
    end else if (cur_byte < SIS_TRG_BYTE) begin
      sig_word = snap_frm_next;
      rel = cur_byte - SIS_FRM_BYTE;
    end else if (cur_byte < SIS_USR_BYTE) begin
      sig_word = snap_trg_next;
      rel = cur_byte - SIS_TRG_BYTE;
    end
    sig_byte = sig_word[{rel[1:0], 3'b000} +: 8];
    out_data_next = ins_now ? sig_byte : in_data;
    ins_next = ins_now;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ins_reg <= 1'b0;
      out_valid_reg <= 1'b0;
      out_data_reg <= 8'h00;
      out_sof_reg <= 1'b0;
      out_eol_reg <= 1'b0;
      out_eof_reg <= 1'b0;
      out_pad_reg <= 1'b0;
    end else begin
      ins_reg <= ins_next;
      out_valid_reg <= in_valid;
      out_data_reg <= out_data_next;
      out_sof_reg <= in_valid && in_sof;
      out_eol_reg <= in_valid && in_eol;
      out_eof_reg <= in_valid && in_eof;
      out_pad_reg <= in_valid && in_pad;
    end
  end

  assign out_valid = out_valid_reg;
  assign out_data = out_data_reg;
  assign out_sof = out_sof_reg;
  assign out_eol = out_eol_reg;
  assign out_eof = out_eof_reg;
  assign out_pad = out_pad_reg;

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_present;
    @(posedge clk) disable iff (reset) reg_rd && reg_addr == SIS_CTRL_ADDR |=> reg_rdata[SIS_PRESENT_BIT];
  endproperty
  a_present: assert property (p_present) else $error("presence flag not read as one");

  property p_off_passes;
    @(posedge clk) disable iff (reset) in_valid && !en_next |=> out_data == $past(in_data) && !ins_reg;
  endproperty
  a_off_passes: assert property (p_off_passes) else $error("byte changed while disabled");

  property p_line_match;
    @(posedge clk) disable iff (reset) ins_now |-> (in_pad ? cur_line == image_height : cur_line < image_height);
  endproperty
  a_line_match: assert property (p_line_match) else $error("insertion outside chosen line");

  property p_pad_only;
    @(posedge clk) disable iff (reset) ins_reg |-> out_pad == (target_reg == image_height);
  endproperty
  a_pad_only: assert property (p_pad_only) else $error("signature in wrong region");

  property p_ct_byte0;
    @(posedge clk) disable iff (reset) ins_now && cur_byte == SIS_CT_BYTE |=> out_data == snap_ct_reg[7:0];
  endproperty
  a_ct_byte0: assert property (p_ct_byte0) else $error("cycle time low byte wrong");

  property p_frm_byte;
    @(posedge clk) disable iff (reset) ins_now && cur_byte == 5'h07 |=> out_data == snap_frm_reg[31:24];
  endproperty
  a_frm_byte: assert property (p_frm_byte) else $error("frame counter top byte wrong");

  property p_ct_latch;
    @(posedge clk) disable iff (reset) integration_start |=> ct_latch_reg == $past(cycle_time);
  endproperty
  a_ct_latch: assert property (p_ct_latch) else $error("cycle time not latched");

  property p_frm_inc;
    @(posedge clk) disable iff (reset) frame_readout |=> frame_cnt_reg == $past(frame_cnt_reg) + 32'h00000001;
  endproperty
  a_frm_inc: assert property (p_frm_inc) else $error("frame counter did not advance");

  property p_trg_hold;
    @(posedge clk) disable iff (reset) !ext_trigger |=> $stable(trig_cnt_reg);
  endproperty
  a_trg_hold: assert property (p_trg_hold) else $error("trigger counter moved without trigger");

  property p_trg_read;
    @(posedge clk) disable iff (reset) reg_rd && reg_addr == SIS_TRGCNT_ADDR && !ext_trigger
      |=> reg_rdata[31:0] == trig_cnt_reg;
  endproperty
  a_trg_read: assert property (p_trg_read) else $error("trigger counter read mismatch");

  c_insert: cover property (@(posedge clk) disable iff (reset) ins_reg && !out_pad);
  c_insert_pad: cover property (@(posedge clk) disable iff (reset) ins_reg && out_pad);
  c_from_bottom: cover property (@(posedge clk) disable iff (reset) ins_now && insert_line_reg[15]);
endmodule : sis_inserter
`default_nettype wire

// ---- shared/sis_pkg.sv ----
// Package with register map, field layout and timing constants of the signature inserter
`default_nettype none
package sis_pkg;
  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [31:0] SIS_CTRL_ADDR = 32'hf1000630;
  localparam logic [31:0] SIS_USER_ADDR = 32'hf1000634;
  localparam logic [31:0] SIS_FRMCNT_ADDR = 32'hf1000614;
  localparam logic [31:0] SIS_TRGCNT_ADDR = 32'hf1000624;
  // ************************************************************
  // Control fields, bit 0 of the map is the word's top bit
  // ************************************************************
  localparam int SIS_PRESENT_BIT = 31;
  localparam int SIS_ON_BIT = 25;
  localparam int SIS_LINE_LSB = 0;
  localparam int SIS_LINE_W = 16;
  localparam logic SIS_ON_RESET = 1'h0;
  localparam logic [15:0] SIS_LINE_RESET = 16'h0000;
  localparam logic [31:0] SIS_USER_RESET = 32'h00000000;
  // ************************************************************
  // Signature layout, byte offsets within the chosen line
  // ************************************************************
  localparam logic [4:0] SIS_CT_BYTE = 5'h00;
  localparam logic [4:0] SIS_FRM_BYTE = 5'h04;
  localparam logic [4:0] SIS_TRG_BYTE = 5'h08;
  localparam logic [4:0] SIS_USR_BYTE = 5'h0c;
  localparam logic [4:0] SIS_LEN = 5'h10;
  // ************************************************************
  // Cycle timer
  // ************************************************************
  localparam int CLK_HZ = 100000000;
  localparam int CT_OFFSET_HZ = 24576000;
  localparam int CT_CYCLE_HZ = 8000;
  localparam logic [13:0] CT_ACC_STEP = 14'(CT_OFFSET_HZ / CT_CYCLE_HZ);
  localparam logic [13:0] CT_ACC_MOD = 14'(CLK_HZ / CT_CYCLE_HZ);
  localparam logic [11:0] CT_OFFSET_MAX = 12'hbff;
  localparam logic [12:0] CT_CYCLES_MAX = 13'h1f3f;
  localparam logic [6:0] CT_SECONDS_MAX = 7'h7f;
endpackage : sis_pkg
`default_nettype wire

// ---- rtl/sis_cycle_timer.sv ----
// Nested bus cycle timer: offset, cycles and seconds
`timescale 1ns/1ps
`default_nettype none
module sis_cycle_timer
  import sis_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  output logic [31:0] cycle_time
);
  logic [13:0] acc_reg, acc_next;
  logic [11:0] off_reg, off_next;
  logic [12:0] cyc_reg, cyc_next;
  logic [6:0] sec_reg, sec_next;
  logic [14:0] acc_sum;

  // Fractional accumulator gives 24.576 MHz ticks on average from 100 MHz
  always_comb begin
    acc_sum = {1'b0, acc_reg} + {1'b0, CT_ACC_STEP};
    acc_next = acc_sum[13:0];
    off_next = off_reg;
    cyc_next = cyc_reg;
    sec_next = sec_reg;
    if (acc_sum >= {1'b0, CT_ACC_MOD}) begin
      acc_next = 14'(acc_sum - {1'b0, CT_ACC_MOD});
      if (off_reg == CT_OFFSET_MAX) begin
        off_next = 12'h000;
        if (cyc_reg == CT_CYCLES_MAX) begin
          cyc_next = 13'h0000;
          sec_next = (sec_reg == CT_SECONDS_MAX) ? 7'h00 : sec_reg + 7'h01;
        end else begin
          cyc_next = cyc_reg + 13'h0001;
        end
      end else begin
        off_next = off_reg + 12'h001;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      acc_reg <= 14'h0000;
      off_reg <= 12'h000;
      cyc_reg <= 13'h0000;
      sec_reg <= 7'h00;
    end else begin
      acc_reg <= acc_next;
      off_reg <= off_next;
      cyc_reg <= cyc_next;
      sec_reg <= sec_next;
    end
  end

  assign cycle_time = {sec_reg, cyc_reg, off_reg};

  property p_off_range;
    @(posedge clk) disable iff (reset) off_reg <= CT_OFFSET_MAX && cyc_reg <= CT_CYCLES_MAX;
  endproperty
  a_off_range: assert property (p_off_range) else $error("cycle timer field out of range");
endmodule : sis_cycle_timer
`default_nettype wire

// ---- sim/sis_host_sink.sv ----
// Host side model: collects transported frame bytes into line buffers
`timescale 1ns/1ps
`default_nettype none
module sis_host_sink (
  input wire logic clk,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  input wire logic out_sof,
  input wire logic out_eol,
  input wire logic out_eof,
  input wire logic out_pad
);
  logic [7:0] cap [0:7][0:19];
  int n_eof = 0;
  int n_pad = 0;
  int line_idx = 0;
  int byte_idx = 0;

  // Index restarts on every frame start, so a lost eol cannot shift later frames
  always @(posedge clk) begin
    if (out_valid) begin
      if (out_sof) begin
        line_idx = 0;
        byte_idx = 0;
      end
      cap[line_idx][byte_idx] <= out_data;
      if (out_eof) begin
        n_eof = n_eof + 1;
      end
      if (out_pad) begin
        n_pad = n_pad + 1;
      end
      if (out_eol) begin
        line_idx = line_idx + 1;
        byte_idx = 0;
      end else begin
        byte_idx = byte_idx + 1;
      end
    end
  end
endmodule : sis_host_sink
`default_nettype wire

// ---- sim/tb.sv ----
// Self-checking bench of the signature inserter
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sis_pkg::*;
  logic clk, reset, reg_wr, reg_rd, integration_start, frame_readout, ext_trigger, seq_active;
  logic [31:0] reg_addr, reg_wdata, reg_rdata, seq_user_tag_value, user_v, ct_a, ct_b;
  logic [31:0] fcnt = 32'h0;
  logic [31:0] tcnt = 32'h0;
  logic [15:0] image_height;
  logic in_valid, in_sof, in_eol, in_eof, in_pad, out_valid, out_sof, out_eol, out_eof, out_pad;
  logic [7:0] in_data, out_data;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  int c_a, c_b, d;
  logic [15:0] lines [8] = '{16'h0000, 16'h0000, 16'h0002, 16'hffff, 16'hfffc, 16'h0004, 16'h0004, 16'h0001};
  int pads [8] = '{0, 0, 1, 0, 0, 1, 0, 0};
  int tgts [8] = '{-1, 0, 2, 3, 0, 4, -1, 1};

  sis_inserter DUT (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .image_height(image_height), .integration_start(integration_start),
    .frame_readout(frame_readout), .ext_trigger(ext_trigger), .seq_active(seq_active),
    .seq_user_tag_value(seq_user_tag_value), .in_valid(in_valid), .in_data(in_data), .in_sof(in_sof),
    .in_eol(in_eol), .in_eof(in_eof), .in_pad(in_pad), .out_valid(out_valid), .out_data(out_data),
    .out_sof(out_sof), .out_eol(out_eol), .out_eof(out_eof), .out_pad(out_pad));
  sis_host_sink host (.clk(clk), .out_valid(out_valid), .out_data(out_data), .out_sof(out_sof),
    .out_eol(out_eol), .out_eof(out_eof), .out_pad(out_pad));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Run is about 2100 cycles, so this only trips on a hang
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      finish_test();
    end
  end

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Ideal cycle time after k clocks of 10 ns, from the nominal tick rates
  function automatic logic [31:0] ct_model(input int k);
    int t;
    t = k * (CT_OFFSET_HZ / CT_CYCLE_HZ) / (CLK_HZ / CT_CYCLE_HZ);
    return {7'(t / CT_OFFSET_HZ % 128), 13'(t / 3072 % 8000), 12'(t % 3072)};
  endfunction : ct_model

  task automatic reg_write(input logic [31:0] a, input logic [31:0] v);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : reg_write

  task automatic reg_check(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] v;
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    check(v, exp);
    @(posedge clk);
  endtask : reg_check

  task automatic pulse(input int which);
    case (which)
      0: integration_start <= 1'b1;
      1: frame_readout <= 1'b1;
      default: ext_trigger <= 1'b1;
    endcase
    @(posedge clk);
    integration_start <= 1'b0;
    frame_readout <= 1'b0;
    ext_trigger <= 1'b0;
    @(posedge clk);
  endtask : pulse

  // Four image lines of 20 bytes, then pad_n padding lines
  task automatic send_frame(input int pad_n);
    for (int l = 0; l < 4 + pad_n; l++) begin
      for (int b = 0; b < 20; b++) begin
        in_valid <= 1'b1;
        in_data <= {l[2:0], b[4:0]};
        in_sof <= (l == 0 && b == 0);
        in_eol <= (b == 19);
        in_eof <= (b == 19 && l == 3 + pad_n);
        in_pad <= (l >= 4);
        @(posedge clk);
      end
    end
    in_valid <= 1'b0;
    in_sof <= 1'b0;
    in_eol <= 1'b0;
    in_eof <= 1'b0;
    in_pad <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : send_frame

  task automatic check_frame(input int tgt, input int pad_n, input logic [31:0] ct);
    logic [127:0] sig;
    logic [7:0] exp;
    sig = {user_v, tcnt, fcnt, ct};
    for (int l = 0; l < 4 + pad_n; l++) begin
      for (int b = 0; b < 20; b++) begin
        exp = {l[2:0], b[4:0]};
        if (l == tgt && b < 16) begin
          exp = sig[8*b +: 8];
        end
        check({24'h0, host.cap[l][b]}, {24'h0, exp});
      end
    end
  endtask : check_frame

  task automatic finish_test();
    if (n_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    reset = 1'b1;
    {reg_wr, reg_rd, integration_start, frame_readout, ext_trigger, seq_active} = 6'h00;
    {reg_addr, reg_wdata, seq_user_tag_value} = 96'h0;
    {in_valid, in_sof, in_eol, in_eof, in_pad, in_data} = 13'h0000;
    image_height = 16'h0004;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    reg_check(SIS_CTRL_ADDR, 32'h80000000);
    reg_check(SIS_USER_ADDR, 32'h00000000);
    reg_check(32'hf1000638, 32'h00000000);
    reg_write(SIS_CTRL_ADDR, 32'hffffffff);
    reg_check(SIS_CTRL_ADDR, 32'h8200ffff);
    reg_write(SIS_CTRL_ADDR, 32'h00000000);
    reg_check(SIS_CTRL_ADDR, 32'h80000000);
    reg_write(SIS_FRMCNT_ADDR, 32'h12345678);
    repeat (3) begin
      pulse(1);
      fcnt++;
    end
    repeat (2) begin
      pulse(2);
      tcnt++;
    end
    reg_check(SIS_FRMCNT_ADDR, fcnt);
    reg_check(SIS_TRGCNT_ADDR, tcnt);
    pulse(0);
    c_a = cyc;
    // Off, top, mid, bottom, top from below, padding, missing padding, sequence
    for (int i = 0; i < 8; i++) begin
      user_v = 32'ha5000000 + i;
      reg_write(SIS_USER_ADDR, user_v);
      reg_write(SIS_CTRL_ADDR, {6'h00, (i != 0), 9'h000, lines[i]});
      seq_active <= (i == 7);
      seq_user_tag_value <= 32'h5eed0000 + i;
      if (i == 7) begin
        user_v = 32'h5eed0007;
      end
      pulse(1);
      fcnt++;
      if (i % 2 == 1) begin
        pulse(2);
        tcnt++;
      end
      send_frame(pads[i]);
      if (i == 1) begin
        ct_a = {host.cap[0][3], host.cap[0][2], host.cap[0][1], host.cap[0][0]};
        check(ct_a, ct_model(c_a - 7));
      end
      check_frame(tgts[i], pads[i], ct_a);
    end
    check({31'h0, ct_a[11:0] <= CT_OFFSET_MAX}, 32'h1);
    // Second snapshot exactly 2000 clocks after the first
    seq_active <= 1'b0;
    user_v = 32'ha5000007;
    while (cyc < c_a + 1998) @(posedge clk);
    pulse(0);
    c_b = cyc;
    reg_write(SIS_CTRL_ADDR, 32'h02000000);
    pulse(1);
    fcnt++;
    send_frame(0);
    ct_b = {host.cap[0][3], host.cap[0][2], host.cap[0][1], host.cap[0][0]};
    check(ct_b, ct_model(c_b - 7));
    check_frame(0, 0, ct_b);
    d = (int'(ct_b[24:12]) * 3072 + int'(ct_b[11:0])) - (int'(ct_a[24:12]) * 3072 + int'(ct_a[11:0]));
    check({31'h0, (d == 491 || d == 492)}, 32'h1);
    check(32'(host.n_eof), 32'h00000009);
    check(32'(host.n_pad), 32'h00000028);
    finish_test();
  end
endmodule : tb
`default_nettype wire
